// file: rtl/swkey_pkg.sv
// Shared constants for the thumbwheel and ten-key readers
package swkey_pkg;
  localparam int          WORD_W        = 16;
  localparam int          STEPS         = 16;     // Scan cycles per switch round
  localparam int          STEP_W        = 4;
  localparam int          STRB_LO       = 0;      // Control strobes on out bits 00..04
  localparam int          STRB_W        = 5;
  localparam int          ROUND_BIT     = 5;      // Round-complete flag bit
  localparam int          DATA_W        = 4;      // Data lines per digit
  localparam int          SW_IN_W       = 8;      // Switch input points 0..7
  localparam int          KEYS          = 10;
  localparam int          ANY_KEY_BIT   = 10;
  localparam logic [15:0] DIGITS_FOUR   = 16'h0000;
  localparam logic [15:0] DIGITS_EIGHT  = 16'h0001;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
endpackage : swkey_pkg

// file: rtl/switch_and_keypad_reader.sv
// Thumbwheel switch and ten-key keypad readers driven by scan enables
`timescale 1ns/1ps
// Contract
// - Strobes on out bits 0-4, sample data
// - Four digits low word, eight use both
// - Full read every 16 scans, repeating
// - Round flag bit 5 once per 16
// - Work word not cleared on first cycle
// - Reactivation restarts at sequence step zero
// - Keypad builds eight BCD digits in pair
// - Key flag holds until different key
// - Bit 10 set while any key held
// - Press shifts pair left, new digit low
// - Held key blocks other key presses
// - Reactivation restarts keypad reading at start
// - Keypad keeps no private work word
module switch_and_keypad_reader (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  // Scan control
  input  wire logic        SCAN_EN,
  input  wire logic        SW_ACTIVE,
  input  wire logic        KEY_ACTIVE,
  input  wire logic [15:0] DIGIT_COUNT_SELECT,
  // Switch points
  input  wire logic [7:0]  SW_IN,
  output logic      [15:0] SW_OUT,
  output logic      [15:0] SW_RESULT_LO,
  output logic      [15:0] SW_RESULT_HI,
  output logic      [15:0] SCAN_WORK_WORD,
  // Keypad points
  input  wire logic [15:0] KEY_IN,
  output logic      [15:0] BCD_SHIFT_LO,
  output logic      [15:0] BCD_SHIFT_HI,
  output logic      [15:0] KEY_FLAG_WORD
);

  // Two-stage synchronisers on pin inputs
  logic [7:0]  sw_meta_r, sw_sync_r;
  logic [9:0]  key_meta_r, key_sync_r;
  always_ff @(posedge MCLK) begin
    sw_meta_r  <= SW_IN;
    sw_sync_r  <= sw_meta_r;
    key_meta_r <= KEY_IN[9:0];
    key_sync_r <= key_meta_r;
  end

  // Lowest pressed key index
  function automatic logic [3:0] key_code(input logic [9:0] k);
    logic [3:0] c;
    c = 4'h0;
    for (int i = swkey_pkg::KEYS - 1; i >= 0; i--) begin
      if (k[i]) c = 4'(i);
    end
    return c;
  endfunction

  // ---------------- Thumbwheel reader ----------------
  logic        sw_was_active_r;
  logic [3:0]  step_r;
  logic        eight_r;
  logic [31:0] shift_r;
  logic        round_r;
  logic [4:0]  strobe_r;
  wire         sw_run   = SCAN_EN && SW_ACTIVE;
  wire         sw_first = sw_run && !sw_was_active_r;
  wire  [3:0]  ndig     = eight_r ? 4'd8 : 4'd4;

  // Step decode for this scan; first active scan runs step 0 directly
  wire         round_start = sw_run && (sw_first || step_r == 4'h0);
  wire         eight_nxt   = round_start ? (DIGIT_COUNT_SELECT == swkey_pkg::DIGITS_EIGHT)
                                         : eight_r;
  wire  [3:0]  cur_step    = sw_first ? 4'h0 : step_r;
  wire  [3:0]  cur_digit   = {1'b0, cur_step[3:1]};
  wire         sample_now  = sw_run && cur_step[0] && (cur_digit < ndig);
  wire         last_step   = sw_run && !sw_first && step_r == 4'(swkey_pkg::STEPS - 1);
  // Eighth digit is sampled on the copy step, so results take the next shift value
  wire  [31:0] shift_nxt   = sample_now ? {shift_r[27:0], sw_sync_r[3:0]} : shift_r;

  // Activity history for restart detection
  always_ff @(posedge MCLK) begin
    if (SYS_RST) sw_was_active_r <= 1'b0;
    else if (SCAN_EN) sw_was_active_r <= SW_ACTIVE;
  end

  // Step counter: two scans per digit, round of 16
  always_ff @(posedge MCLK) begin
    if (SYS_RST) step_r <= 4'h0;
    else if (sw_first) step_r <= 4'h1;
    else if (sw_run) step_r <= step_r + 4'h1;
  end

  // Digit count captured at round start
  always_ff @(posedge MCLK) begin
    if (SYS_RST) eight_r <= 1'b0;
    else eight_r <= eight_nxt;
  end

  // Strobes: bit 4 chip select, bits 0-3 digit read select; sample on odd steps
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      strobe_r <= 5'h00;
      shift_r  <= 32'h0;
    end else if (sw_run) begin
      strobe_r <= (cur_digit < ndig) ? {1'b1, cur_digit} : 5'h00;
      shift_r  <= shift_nxt;
    end
  end

  // Result words and round flag on final step
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      SW_RESULT_LO <= swkey_pkg::WORD_RESET;
      SW_RESULT_HI <= swkey_pkg::WORD_RESET;
      round_r      <= 1'b0;
    end else if (sw_run) begin
      round_r <= last_step;
      if (last_step) begin
        SW_RESULT_LO <= shift_nxt[15:0];
        if (eight_r) SW_RESULT_HI <= shift_nxt[31:16];
      end
    end
  end

  // Work word mirrors sequence step; no clear on activation
  always_ff @(posedge MCLK) begin
    if (SYS_RST) SCAN_WORK_WORD <= swkey_pkg::WORD_RESET;
    else if (sw_run) SCAN_WORK_WORD <= {11'h0, eight_nxt, sw_first ? 4'h1 : step_r + 4'h1};
  end

  assign SW_OUT = {10'h0, round_r, strobe_r};

  // ---------------- Ten-key reader ----------------
  logic [9:0] held_r;
  wire        key_run = SCAN_EN && KEY_ACTIVE;
  wire        any_key = |key_sync_r;
  wire        new_press = any_key && (held_r == 10'h0);

  // Held-key latch, restarts cleanly when reactivated
  always_ff @(posedge MCLK) begin
    if (SYS_RST) held_r <= 10'h0;
    else if (SCAN_EN && !KEY_ACTIVE) held_r <= 10'h0;
    else if (key_run) begin
      if (!(|(key_sync_r & held_r))) held_r <= new_press ? key_sync_r & (~key_sync_r + 10'h1) : 10'h0;
    end
  end

  // Shift pair and key flags
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      BCD_SHIFT_LO  <= swkey_pkg::WORD_RESET;
      BCD_SHIFT_HI  <= swkey_pkg::WORD_RESET;
      KEY_FLAG_WORD <= swkey_pkg::WORD_RESET;
    end else if (key_run) begin
      KEY_FLAG_WORD[swkey_pkg::ANY_KEY_BIT] <= any_key;
      if (new_press) begin
        {BCD_SHIFT_HI, BCD_SHIFT_LO} <= {BCD_SHIFT_HI[11:0], BCD_SHIFT_LO,
                                          key_code(key_sync_r)};
        KEY_FLAG_WORD[9:0] <= 10'h1 << key_code(key_sync_r);
      end
    end
  end

  // Final step of a round, shared by the round flag and eight-digit copy checks
  sequence last_step_s;
    sw_run && !sw_first && step_r == 4'hf;
  endsequence

  // Round flag exactly at end of each round, steps one per scan
  chk_round_flag: assert property (@(posedge MCLK) disable iff (SYS_RST)
    last_step_s |=> SW_OUT[5])
    else $error("round flag missing");
  chk_round_only: assert property (@(posedge MCLK) disable iff (SYS_RST)
    SW_OUT[5] |-> step_r == 4'h0)
    else $error("round flag off step");
  chk_restart_step: assert property (@(posedge MCLK) disable iff (SYS_RST)
    sw_first |=> step_r == 4'h1)
    else $error("no restart");
  chk_step_adv: assert property (@(posedge MCLK) disable iff (SYS_RST)
    sw_run && !sw_first |=> step_r == $past(step_r) + 4'h1)
    else $error("step skipped");
  chk_work_step: assert property (@(posedge MCLK) disable iff (SYS_RST)
    sw_run |=> SCAN_WORK_WORD[3:0] == step_r)
    else $error("work word step wrong");

  // Switch strobes and result words
  chk_strobe_cs: assert property (@(posedge MCLK) disable iff (SYS_RST)
    SW_OUT[3:0] != 4'h0 |-> SW_OUT[4])
    else $error("read without select");
  chk_strobe_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
    sw_run && !sw_first && step_r[0] |=> $stable(SW_OUT[4:0]))
    else $error("strobe moved while sampling");
  chk_four_keep: assert property (@(posedge MCLK) disable iff (SYS_RST)
    sw_run && !eight_r |=> SW_RESULT_HI == $past(SW_RESULT_HI))
    else $error("hi word touched");
  chk_eight_copy: assert property (@(posedge MCLK) disable iff (SYS_RST)
    last_step_s ##0 eight_r |=>
      {SW_RESULT_HI, SW_RESULT_LO} == $past({shift_r[27:0], sw_sync_r[3:0]}))
    else $error("eight digit result wrong");

  // Ten-key flags, shift pair and held key
  chk_any_key: assert property (@(posedge MCLK) disable iff (SYS_RST)
    key_run |=> KEY_FLAG_WORD[10] == $past(any_key))
    else $error("any key flag wrong");
  chk_flag_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !(key_run && new_press) |=> KEY_FLAG_WORD[9:0] == $past(KEY_FLAG_WORD[9:0]))
    else $error("key flag changed");
  chk_key_onehot: assert property (@(posedge MCLK) disable iff (SYS_RST)
    key_run && new_press |=> $onehot(KEY_FLAG_WORD[9:0]))
    else $error("key flag not single");
  chk_shift_in: assert property (@(posedge MCLK) disable iff (SYS_RST)
    key_run && new_press |=> BCD_SHIFT_LO[15:4] == $past(BCD_SHIFT_LO[11:0]))
    else $error("shift wrong");
  chk_held_block: assert property (@(posedge MCLK) disable iff (SYS_RST)
    key_run && (|(held_r & key_sync_r)) |=> $stable(BCD_SHIFT_LO))
    else $error("shift while key held");
  chk_key_restart: assert property (@(posedge MCLK) disable iff (SYS_RST)
    SCAN_EN && !KEY_ACTIVE |=> held_r == 10'h000)
    else $error("held key kept while idle");

  // Reset clears sequence, outputs and key state
  chk_reset_clear: assert property (@(posedge MCLK)
    SYS_RST |=> step_r == 4'h0 && SW_OUT == 16'h0000 && BCD_SHIFT_LO == 16'h0000 &&
                KEY_FLAG_WORD == 16'h0000)
    else $error("reset left state");

endmodule // switch_and_keypad_reader

// file: dv/switch_pad_model.sv
// Behavioural thumbwheel switch bank and ten-key pad
`timescale 1ns/1ps
module switch_pad_model (
  // Clock
  input  wire logic        clk,
  // Switch side
  input  wire logic [15:0] strobe,
  input  wire logic [3:0]  ofs,
  output logic      [7:0]  sw_data,
  // Keypad side
  input  wire logic [9:0]  keys,
  output logic      [15:0] key_lines
);
  logic [7:0] last_r = 8'h00;
  logic [7:0] digit;
  // Selected digit reads index plus one plus offset
  assign digit = {4'h0, strobe[3:0] + 4'h1 + ofs};
  // Deselected lines show the inverse of the last value
  always @(posedge clk) if (strobe[4]) last_r <= digit;
  assign sw_data = strobe[4] ? digit : ~last_r;
  // Keys 0-9 wired one to one
  assign key_lines = {6'h00, keys};
endmodule // switch_pad_model

// file: dv/switch_and_keypad_reader_test.sv
// Self-checking bench for the switch and keypad readers
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module switch_and_keypad_reader_test;
  typedef struct {logic [9:0] k; logic [15:0] lo;} row_t;
  logic        MCLK = 1'b0, SYS_RST = 1'b1, SCAN_EN = 1'b0;
  logic        SW_ACTIVE = 1'b0, KEY_ACTIVE = 1'b0;
  logic [15:0] DIGIT_COUNT_SELECT = 16'h0001;
  logic [9:0]  keys = 10'h000;
  logic [3:0]  ofs = 4'h0;
  logic [7:0]  SW_IN;
  logic [15:0] KEY_IN, SW_OUT, SW_RESULT_LO, SW_RESULT_HI, SCAN_WORK_WORD;
  logic [15:0] BCD_SHIFT_LO, BCD_SHIFT_HI, KEY_FLAG_WORD;
  int          mismatches = 0, num_checks = 0, cycles = 0;
  logic [7:0]  flags;
  row_t        rows [5] = '{'{10'h002, 16'h0001}, '{10'h004, 16'h0012},
    '{10'h008, 16'h0123}, '{10'h010, 16'h1234}, '{10'h020, 16'h2345}};
  switch_and_keypad_reader i_switch_and_keypad_reader (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .SCAN_EN(SCAN_EN), .SW_ACTIVE(SW_ACTIVE), .KEY_ACTIVE(KEY_ACTIVE),
    .DIGIT_COUNT_SELECT(DIGIT_COUNT_SELECT), .SW_IN(SW_IN), .SW_OUT(SW_OUT),
    .SW_RESULT_LO(SW_RESULT_LO), .SW_RESULT_HI(SW_RESULT_HI),
    .SCAN_WORK_WORD(SCAN_WORK_WORD), .KEY_IN(KEY_IN), .BCD_SHIFT_LO(BCD_SHIFT_LO),
    .BCD_SHIFT_HI(BCD_SHIFT_HI), .KEY_FLAG_WORD(KEY_FLAG_WORD));
  switch_pad_model i_switch_pad_model (.clk(MCLK), .strobe(SW_OUT), .ofs(ofs),
    .sw_data(SW_IN), .keys(keys), .key_lines(KEY_IN));
  // Clock and hang guard
  always #50 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  // One scan pulse after the pin synchronisers settle
  task automatic scan();
    repeat (3) @(posedge MCLK);
    #1 SCAN_EN = 1'b1;
    @(posedge MCLK);
    #1 SCAN_EN = 1'b0;
  endtask
  // Verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge MCLK);
    #1 SYS_RST = 1'b0;
    `CHK("reset pair", 16'h0000, BCD_SHIFT_LO)
    `CHK("reset flags", 16'h0000, KEY_FLAG_WORD)
    `CHK("reset work", 16'h0000, SCAN_WORK_WORD)
    KEY_ACTIVE = 1'b1;
    foreach (rows[i]) begin
      keys = rows[i].k;
      scan();
      `CHK("pair low", rows[i].lo, BCD_SHIFT_LO)
      `CHK("key press", {6'h01, rows[i].k}, KEY_FLAG_WORD)
      keys = 10'h000;
      scan();
      `CHK("key release", {6'h00, rows[i].k}, KEY_FLAG_WORD)
    end
    `CHK("pair high", 16'h0001, BCD_SHIFT_HI)
    // Second key while one is held
    keys = 10'h080;
    scan();
    keys = 10'h180;
    scan();
    `CHK("pair held", 16'h3457, BCD_SHIFT_LO)
    `CHK("key held", 16'h0480, KEY_FLAG_WORD)
    // Idle scan drops the held key, reactivation reads it afresh
    KEY_ACTIVE = 1'b0;
    scan();
    KEY_ACTIVE = 1'b1;
    scan();
    `CHK("key restart", 16'h4577, BCD_SHIFT_LO)
    `CHK("restart high", 16'h0123, BCD_SHIFT_HI)
    `CHK("restart flag", 16'h0480, KEY_FLAG_WORD)
    keys = 10'h000;
    KEY_ACTIVE = 1'b0;
    // Eight-digit round
    SW_ACTIVE = 1'b1;
    scan();
    `CHK("first strobe", 16'h0010, SW_OUT)
    repeat (15) scan();
    `CHK("switch high", 16'h1234, SW_RESULT_HI)
    `CHK("switch low", 16'h5678, SW_RESULT_LO)
    `CHK("round out", 16'h0037, SW_OUT)
    `CHK("eight work", 16'h0010, SCAN_WORK_WORD)
    // Stop mid-round, restart as four digits
    repeat (5) scan();
    SW_ACTIVE = 1'b0;
    scan();
    SW_ACTIVE = 1'b1;
    DIGIT_COUNT_SELECT = 16'h0000;
    ofs = 4'h1;
    flags = 8'h00;
    scan();
    repeat (16) begin
      scan();
      flags = flags + {7'h00, SW_OUT[5]};
    end
    `CHK("round flags", 8'h01, flags)
    `CHK("four low", 16'h2345, SW_RESULT_LO)
    `CHK("four high", 16'h1234, SW_RESULT_HI)
    `CHK("four work", 16'h0001, SCAN_WORK_WORD)
    // Reset in mid-run, then a scan straight after release
    SYS_RST = 1'b1;
    repeat (2) @(posedge MCLK);
    #1 SYS_RST = 1'b0;
    `CHK("rst out", 16'h0000, SW_OUT)
    `CHK("rst high", 16'h0000, SW_RESULT_HI)
    `CHK("rst pair high", 16'h0000, BCD_SHIFT_HI)
    `CHK("rst flags", 16'h0000, KEY_FLAG_WORD)
    `CHK("rst work", 16'h0000, SCAN_WORK_WORD)
    scan();
    `CHK("rst restart", 16'h0010, SW_OUT)
    `CHK("rst step", 16'h0001, SCAN_WORK_WORD)
    stop_test();
  end
endmodule // switch_and_keypad_reader_test
